/* File: hdl/sts_consts.vh */
// Constants for the S/T line framing block: timing, frame layout and register map.
`ifndef STS_CONSTS_VH
`define STS_CONSTS_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define STS_CLK_HZ 125000000
`define STS_BIT_HZ 192000
`define STS_BIT_CYC (`STS_CLK_HZ / `STS_BIT_HZ)
`define STS_BIT_CYC_LAST 10'd650

// ----------------------------------------------------------------------------
// Frame layout, bit positions 0..47
// ----------------------------------------------------------------------------
`define STS_POS_F 6'd0
`define STS_POS_L1 6'd1
`define STS_POS_B1A 6'd2
`define STS_POS_E1 6'd10
`define STS_POS_D1 6'd11
`define STS_POS_A 6'd12
`define STS_POS_FA 6'd13
`define STS_POS_N 6'd14
`define STS_POS_B2A 6'd15
`define STS_POS_E2 6'd23
`define STS_POS_D2 6'd24
`define STS_POS_M 6'd25
`define STS_POS_B1B 6'd26
`define STS_POS_E3 6'd34
`define STS_POS_D3 6'd35
`define STS_POS_S 6'd36
`define STS_POS_B2B 6'd37
`define STS_POS_E4 6'd45
`define STS_POS_D4 6'd46
`define STS_POS_LAST 6'd47
`define STS_VIOL_WIN 6'd14
`define STS_WIN_CLOSE 6'd40

// Position kinds.
`define STS_K_F 4'h0
`define STS_K_L 4'h1
`define STS_K_B1 4'h2
`define STS_K_B2 4'h3
`define STS_K_E 4'h4
`define STS_K_D 4'h5
`define STS_K_A 4'h6
`define STS_K_FA 4'h7
`define STS_K_N 4'h8
`define STS_K_M 4'h9
`define STS_K_S 4'hA

// Framer: three patterns to gain sync, three errors to lose it.
`define STS_SYNC_LAST 2'h2

// ----------------------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------------------
`define STS_REG_CTRL 8'h00
`define STS_REG_TXDATA 8'h04
`define STS_REG_STATUS 8'h08
`define STS_REG_RXDATA 8'h0C
`define STS_C_NT 0
`define STS_C_MF 1
`define STS_C_MS 2
`define STS_C_Q 3
`define STS_C_PHASE 4
`define STS_C_FORCE 5
`define STS_C_TXEN 6
`define STS_S_SYNC 0
`define STS_S_RXQ 1
`define STS_S_RXMF 2
`define STS_S_RXMS 3
`define STS_S_PHASE 4
`define STS_RESP_OKAY 2'h0
`define STS_RESP_SLVERR 2'h2

`endif

/* File: hdl/sts_frame_logic.v */
// S/T line framer: pseudo-ternary coder, frame builder, sync hunter, multiframe.
//
// The AXI4-Lite register port and the address map were decided locally.
`include "sts_consts.vh"

module sts_frame_logic (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // AXI4-Lite write channels
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Line side
  output reg tx_pos_q,
  output reg tx_neg_q,
  input wire rx_pos,
  input wire rx_neg,
  // System side
  output reg channel_access_window_n,
  output wire frame_phase_out
);

  // --------------------------------------------------------------------------
  // Position helpers
  // --------------------------------------------------------------------------
  function [3:0] pos_kind;
    input [5:0] p;
    begin
      if (p == `STS_POS_F)
        pos_kind = `STS_K_F;
      else if (p == `STS_POS_L1 || p == `STS_POS_LAST)
        pos_kind = `STS_K_L;
      else if ((p >= `STS_POS_B1A && p < `STS_POS_E1) || (p >= `STS_POS_B1B && p < `STS_POS_E3))
        pos_kind = `STS_K_B1;
      else if ((p >= `STS_POS_B2A && p < `STS_POS_E2) || (p >= `STS_POS_B2B && p < `STS_POS_E4))
        pos_kind = `STS_K_B2;
      else if (p == `STS_POS_E1 || p == `STS_POS_E2 || p == `STS_POS_E3 || p == `STS_POS_E4)
        pos_kind = `STS_K_E;
      else if (p == `STS_POS_A)
        pos_kind = `STS_K_A;
      else if (p == `STS_POS_FA)
        pos_kind = `STS_K_FA;
      else if (p == `STS_POS_N)
        pos_kind = `STS_K_N;
      else if (p == `STS_POS_M)
        pos_kind = `STS_K_M;
      else if (p == `STS_POS_S)
        pos_kind = `STS_K_S;
      else
        pos_kind = `STS_K_D;
    end
  endfunction

  // Bit index within a B octet, most significant bit first on the line.
  function [2:0] oct_idx;
    input [5:0] p;
    reg [5:0] d;
    begin
      d = 6'h00;
      if (p < `STS_POS_E1)
        d = p - `STS_POS_B1A;
      else if (p < `STS_POS_E2)
        d = p - `STS_POS_B2A;
      else if (p < `STS_POS_E3)
        d = p - `STS_POS_B1B;
      else
        d = p - `STS_POS_B2B;
      oct_idx = ~d[2:0];
    end
  endfunction

  function [1:0] d_idx;
    input [5:0] p;
    begin
      d_idx = {p >= `STS_POS_D3, (p >= `STS_POS_D2 && p < `STS_POS_D3) || p >= `STS_POS_D4};
    end
  endfunction

  // --------------------------------------------------------------------------
  // Control and data registers
  // --------------------------------------------------------------------------
  reg nt_mode_q, tx_en_q, tx_multiframe_start, ms_ctrl_q, tx_maint_q_bit;
  reg phase_q, force_q, m_bit_q, s_bit_q;
  reg [7:0] tx_b1_q, tx_b2_q, rx_b1_q, rx_b2_q;
  reg [3:0] tx_d_q, rx_d_q;
  reg rx_maint_q_bit, rx_multiframe_start_flag, rx_ms_q, te_phase_q;
  reg [31:0] rd_mux;
  reg rd_hit;

  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && !s_axi_rvalid;
  wire [7:0] wr_addr = {s_axi_awaddr[7:2], 2'b00};
  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  wire wr_ctrl = wr_go && wr_addr == `STS_REG_CTRL && s_axi_wstrb[0];
  wire wr_stat = wr_go && wr_addr == `STS_REG_STATUS && s_axi_wstrb[0];
  wire in_sync;
  wire mf_set;

  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign frame_phase_out = nt_mode_q ? phase_q : te_phase_q;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {nt_mode_q, tx_en_q, tx_multiframe_start, ms_ctrl_q} <= 4'h0;
      {tx_maint_q_bit, phase_q, force_q, m_bit_q, s_bit_q} <= 5'h00;
      tx_b1_q <= 8'hFF;
      tx_b2_q <= 8'hFF;
      tx_d_q <= 4'hF;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `STS_RESP_OKAY;
    end
    else
    begin
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr > `STS_REG_RXDATA) ? `STS_RESP_SLVERR : `STS_RESP_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_ctrl)
      begin
        nt_mode_q <= s_axi_wdata[`STS_C_NT];
        tx_multiframe_start <= s_axi_wdata[`STS_C_MF];
        ms_ctrl_q <= s_axi_wdata[`STS_C_MS];
        tx_maint_q_bit <= s_axi_wdata[`STS_C_Q];
        phase_q <= s_axi_wdata[`STS_C_PHASE];
        force_q <= s_axi_wdata[`STS_C_FORCE];
        tx_en_q <= s_axi_wdata[`STS_C_TXEN];
        // The M/S value is steered by the phase written alongside it.
        if (s_axi_wdata[`STS_C_PHASE])
          s_bit_q <= s_axi_wdata[`STS_C_MS];
        else
          m_bit_q <= s_axi_wdata[`STS_C_MS];
      end
      if (wr_go && wr_addr == `STS_REG_TXDATA)
      begin
        if (s_axi_wstrb[0])
          tx_b1_q <= s_axi_wdata[7:0];
        if (s_axi_wstrb[1])
          tx_b2_q <= s_axi_wdata[15:8];
        if (s_axi_wstrb[2])
          tx_d_q <= s_axi_wdata[19:16];
      end
    end
  end

  always @*
  begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (rd_addr)
      `STS_REG_CTRL:
      begin
        rd_mux[`STS_C_NT] = nt_mode_q;
        rd_mux[`STS_C_MF] = tx_multiframe_start;
        rd_mux[`STS_C_MS] = ms_ctrl_q;
        rd_mux[`STS_C_Q] = tx_maint_q_bit;
        rd_mux[`STS_C_PHASE] = phase_q;
        rd_mux[`STS_C_FORCE] = force_q;
        rd_mux[`STS_C_TXEN] = tx_en_q;
      end
      `STS_REG_TXDATA:
        rd_mux[19:0] = {tx_d_q, tx_b2_q, tx_b1_q};
      `STS_REG_STATUS:
      begin
        rd_mux[`STS_S_SYNC] = in_sync;
        rd_mux[`STS_S_RXQ] = rx_maint_q_bit;
        rd_mux[`STS_S_RXMF] = rx_multiframe_start_flag;
        rd_mux[`STS_S_RXMS] = rx_ms_q;
        rd_mux[`STS_S_PHASE] = frame_phase_out;
      end
      `STS_REG_RXDATA:
        rd_mux[19:0] = {rx_d_q, rx_b2_q, rx_b1_q};
      default:
        rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `STS_RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? `STS_RESP_OKAY : `STS_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Bit clock and transmit frame
  // --------------------------------------------------------------------------
  reg [9:0] div_q;
  reg [5:0] tx_cnt_q;
  reg last_pol_q, viol_pend_q, parity_q, te_q_pend_q, rx_d_last_q;
  reg tx_bit, tx_mark, tx_pol;
  wire tick = div_q == `STS_BIT_CYC_LAST;
  wire [3:0] tx_kind = pos_kind(tx_cnt_q);

  always @*
  begin
    tx_bit = 1'b1;
    case (tx_kind)
      `STS_K_F: tx_bit = 1'b0;
      `STS_K_L: tx_bit = ~parity_q;
      `STS_K_B1: tx_bit = tx_b1_q[oct_idx(tx_cnt_q)];
      `STS_K_B2: tx_bit = tx_b2_q[oct_idx(tx_cnt_q)];
      `STS_K_D: tx_bit = tx_d_q[d_idx(tx_cnt_q)];
      `STS_K_E: tx_bit = nt_mode_q ? rx_d_last_q : 1'b1;
      `STS_K_A: tx_bit = nt_mode_q ? in_sync : 1'b1;
      // NT marks the multiframe with Fa one; TE sends its Q bit in the first Fa after a received multiframe start, else zero.
      `STS_K_FA: tx_bit = nt_mode_q ? tx_multiframe_start : (te_q_pend_q & tx_maint_q_bit);
      `STS_K_N: tx_bit = nt_mode_q ? ~tx_multiframe_start : 1'b1;
      `STS_K_M: tx_bit = nt_mode_q ? m_bit_q : 1'b1;
      `STS_K_S: tx_bit = nt_mode_q ? s_bit_q : 1'b1;
      default: tx_bit = 1'b1;
    endcase
    tx_mark = ~tx_bit;
    if (tx_kind == `STS_K_F)
      tx_pol = last_pol_q;
    else if (viol_pend_q && tx_cnt_q > `STS_POS_L1)
      tx_pol = last_pol_q;
    else
      tx_pol = ~last_pol_q;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= 10'h000;
      tx_cnt_q <= 6'h00;
      last_pol_q <= 1'b0;
      viol_pend_q <= 1'b0;
      parity_q <= 1'b0;
      tx_pos_q <= 1'b0;
      tx_neg_q <= 1'b0;
      channel_access_window_n <= 1'b1;
    end
    else
    begin
      div_q <= tick ? 10'h000 : div_q + 10'h001;
      if (tick)
      begin
        tx_cnt_q <= (tx_cnt_q == `STS_POS_LAST) ? 6'h00 : tx_cnt_q + 6'h01;
        // Window is closed near the frame end, where controls take effect.
        // The outputs launched at this tick carry position tx_cnt_q, so the window
        // follows the bit now on the line, not the next count.
        channel_access_window_n <= (tx_cnt_q >= `STS_WIN_CLOSE);
        tx_pos_q <= tx_en_q & tx_mark & tx_pol;
        tx_neg_q <= tx_en_q & tx_mark & ~tx_pol;
        if (tx_mark)
        begin
          last_pol_q <= tx_pol;
          parity_q <= (tx_kind == `STS_K_L) ? 1'b0 : ~parity_q;
        end
        else if (tx_kind == `STS_K_L)
          parity_q <= 1'b0;
        if (tx_kind == `STS_K_F)
          viol_pend_q <= 1'b1;
        else if (tx_mark && tx_cnt_q > `STS_POS_L1)
          viol_pend_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receive framer
  // --------------------------------------------------------------------------
  wire rxp_s, rxn_s, realign, pattern_ok;
  reg [5:0] rx_cnt_q;
  reg aligned_q, rx_last_pol_q, f_ok_q, v2_q, rx_fa_q, rx_n_q, rx_m_q, rx_s_q;
  wire rx_mark = rxp_s | rxn_s;
  wire rx_bit = ~rx_mark;
  wire rx_viol = rx_mark && (rxp_s == rx_last_pol_q);
  wire [3:0] rx_kind = pos_kind(rx_cnt_q);
  wire frame_end = tick && aligned_q && rx_cnt_q == `STS_POS_LAST;
  // A candidate with no second violation by the window end is dropped at once.
  // Waiting for the frame end would realign just ahead of the same false
  // candidate (a zero Fa) every frame and the hunt would never finish.
  wire early_fail = tick && aligned_q && !in_sync && !force_q &&
                    (rx_cnt_q == `STS_VIOL_WIN + 6'h01) && !v2_q;
  wire te_phase_d = mf_set ? 1'b0 : ~te_phase_q;

  assign pattern_ok = f_ok_q && v2_q;
  assign mf_set = frame_end && !nt_mode_q && in_sync && rx_fa_q && !rx_n_q;

  sts_sync2 u_sync_pos (.clk_sys(clk_sys), .rst_n(rst_n), .din(rx_pos), .dout_q(rxp_s));
  sts_sync2 u_sync_neg (.clk_sys(clk_sys), .rst_n(rst_n), .din(rx_neg), .dout_q(rxn_s));

  sts_sync_hunt u_hunt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .frame_end(frame_end | early_fail),
    .pattern_ok(pattern_ok),
    .force_sync(force_q),
    .in_sync_q(in_sync),
    .realign_q(realign)
  );

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_cnt_q <= 6'h00;
      {aligned_q, rx_last_pol_q, f_ok_q, v2_q} <= 4'h0;
      {rx_fa_q, rx_n_q, rx_m_q, rx_s_q, rx_d_last_q} <= 5'h1F;
      rx_b1_q <= 8'hFF;
      rx_b2_q <= 8'hFF;
      rx_d_q <= 4'hF;
    end
    else if (realign && !force_q)
      aligned_q <= 1'b0;
    else if (tick)
    begin
      if (rx_mark)
        rx_last_pol_q <= rxp_s;
      // Hunting: any violation is taken as a candidate F-bit.
      if (!aligned_q && !force_q && !in_sync)
      begin
        if (rx_viol)
        begin
          aligned_q <= 1'b1;
          rx_cnt_q <= `STS_POS_L1;
          f_ok_q <= 1'b1;
          v2_q <= 1'b0;
        end
      end
      else
      begin
        rx_cnt_q <= (rx_cnt_q == `STS_POS_LAST) ? 6'h00 : rx_cnt_q + 6'h01;
        if (rx_cnt_q == `STS_POS_F)
        begin
          f_ok_q <= rx_viol;
          v2_q <= 1'b0;
        end
        else if (rx_viol && rx_cnt_q <= `STS_VIOL_WIN)
          v2_q <= 1'b1;
        case (rx_kind)
          `STS_K_B1: rx_b1_q[oct_idx(rx_cnt_q)] <= rx_bit;
          `STS_K_B2: rx_b2_q[oct_idx(rx_cnt_q)] <= rx_bit;
          `STS_K_D:
          begin
            rx_d_q[d_idx(rx_cnt_q)] <= rx_bit;
            rx_d_last_q <= rx_bit;
          end
          `STS_K_FA: rx_fa_q <= rx_bit;
          `STS_K_N: rx_n_q <= rx_bit;
          `STS_K_M: rx_m_q <= rx_bit;
          `STS_K_S: rx_s_q <= rx_bit;
          default: rx_fa_q <= rx_fa_q;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receive multiframe status
  // --------------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_maint_q_bit <= 1'b0;
      rx_multiframe_start_flag <= 1'b0;
      rx_ms_q <= 1'b0;
      te_phase_q <= 1'b0;
      te_q_pend_q <= 1'b0;
    end
    else
    begin
      // Set wins over a software clear in the same cycle.
      if (mf_set)
        rx_multiframe_start_flag <= 1'b1;
      else if (wr_stat && s_axi_wdata[`STS_S_RXMF])
        rx_multiframe_start_flag <= 1'b0;
      if (mf_set)
        te_q_pend_q <= 1'b1;
      else if (tick && tx_kind == `STS_K_FA)
        te_q_pend_q <= 1'b0;
      if (frame_end)
      begin
        // Q arrives in the Fa slot of frames the NT sent as multiframe start.
        if (nt_mode_q && tx_multiframe_start)
          rx_maint_q_bit <= rx_fa_q;
        if (!nt_mode_q)
        begin
          te_phase_q <= te_phase_d;
          rx_ms_q <= te_phase_d ? rx_s_q : rx_m_q;
        end
      end
    end
  end

endmodule // sts_frame_logic

/* File: hdl/sts_sync2.v */
// Two-flop synchroniser for one asynchronous input level.
module sts_sync2 (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Level in and out
  input wire din,
  output reg dout_q
);

  reg meta_q;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      dout_q <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      dout_q <= meta_q;
    end
  end

endmodule // sts_sync2

/* File: hdl/sts_sync_hunt.v */
// Receive frame sync state: hunt for three good patterns, drop after three bad.
`include "sts_consts.vh"

module sts_sync_hunt (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Per-frame pattern verdict
  input wire frame_end,
  input wire pattern_ok,
  input wire force_sync,
  // Sync state
  output reg in_sync_q,
  output reg realign_q
);

  reg [1:0] cnt_q;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_sync_q <= 1'b0;
      realign_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      realign_q <= 1'b0;
      // Force holds every counter and the sync state as they are.
      if (frame_end && !force_sync)
      begin
        if (!in_sync_q)
        begin
          if (!pattern_ok)
          begin
            cnt_q <= 2'h0;
            realign_q <= 1'b1;
          end
          else if (cnt_q == `STS_SYNC_LAST)
          begin
            in_sync_q <= 1'b1;
            cnt_q <= 2'h0;
          end
          else
            cnt_q <= cnt_q + 2'h1;
        end
        else if (pattern_ok)
          cnt_q <= 2'h0;
        else if (cnt_q == `STS_SYNC_LAST)
        begin
          in_sync_q <= 1'b0;
          cnt_q <= 2'h0;
          realign_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 2'h1;
      end
    end
  end

endmodule // sts_sync_hunt

/* File: tb/sts_frame_asserts.sv */
// Checker for the S/T line framer: line timing, frame layout and bus answers.
module sts_frame_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Line and system side
  input wire logic tx_pos_q,
  input wire logic tx_neg_q,
  input wire logic channel_access_window_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Bit phase and frame length seen from the access window
  // --------------------------------------------------------------
  logic wp_q, syn_q, lp_q, lv_q;
  logic [1:0] wr_q;
  int ph_q, fr_q, hi_q;
  wire fall = wp_q & ~channel_access_window_n;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // A register write cannot move the line mid-bit; the bit-edge check skips two cycles after it.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {wp_q, syn_q, lp_q, lv_q, wr_q} <= 6'h20;
      {ph_q, fr_q, hi_q} <= '0;
    end
    else
    begin
      wp_q <= channel_access_window_n;
      wr_q <= {wr_q[0], s_axi_awvalid & s_axi_awready};
      ph_q <= fall ? 1 : (ph_q == 650 ? 0 : ph_q + 1);
      fr_q <= fall ? 1 : fr_q + 1;
      syn_q <= syn_q | fall;
      hi_q <= channel_access_window_n ? hi_q + 1 : 0;
      if (tx_pos_q | tx_neg_q)
        {lp_q, lv_q} <= {tx_pos_q, 1'b1};
    end
  end

  chk_no_dual_mark: assert property (!(tx_pos_q && tx_neg_q))
    else $error("both marks high");
  chk_bit_edge: assert property (syn_q && wr_q == 2'b00 &&
    ($changed(tx_pos_q) || $changed(tx_neg_q)) |-> ph_q == 0)
    else $error("line moved off a bit edge");
  chk_frame_len: assert property (fall && syn_q |-> fr_q == 31248)
    else $error("frame length wrong");
  chk_win_high: assert property (fall && syn_q |-> hi_q == 5208)
    else $error("window high span wrong");
  chk_f_viol: assert property (fall && lv_q && (tx_pos_q || tx_neg_q)
    |-> tx_pos_q == lp_q)
    else $error("frame bit not a violation");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write answer late");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer held");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // sts_frame_asserts

/* File: tb/sts_line_model.sv */
// Remote line partner: framed pseudo-ternary traffic aligned to the local frame.
module sts_line_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Local frame reference and traffic enable
  input wire logic window_n,
  input wire logic good,
  // Line toward the framer
  output logic rx_pos,
  output logic rx_neg
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Frame builder
  // --------------------------------------------------------------
  logic wp_q;
  int cnt_q, b;
  assign b = cnt_q / 651;

  // Marks + - - + : frame bit, balance bit, zero Fa as the second violation,
  // closing balance bit. Changes land mid-bit so the framer samples a settled line.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {wp_q, rx_pos, rx_neg} <= 3'b100;
      cnt_q <= -1;
    end
    else
    begin
      wp_q <= window_n;
      if (wp_q && !window_n)
        cnt_q <= 1;
      else if (cnt_q >= 0)
        cnt_q <= (cnt_q == 31247) ? 0 : cnt_q + 1;
      if (cnt_q >= 0 && cnt_q % 651 == 325)
      begin
        rx_pos <= good && (b == 0 || b == 47);
        rx_neg <= good && (b == 1 || b == 13);
      end
    end
  end
endmodule // sts_line_model

/* File: tb/tb_top.sv */
// Testbench for the S/T line framer: registers, line frames and sync hunting.
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------
  logic clk_sys = 0, rst_n = 0, good = 0, pw = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rd;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire tx_pos_q, tx_neg_q, rx_pos, rx_neg, channel_access_window_n, frame_phase_out;
  int failures = 0, num_checks = 0;
  logic [47:0] mk, pl;

  sts_frame_logic i_sts_frame_logic (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_pos_q, .tx_neg_q, .rx_pos, .rx_neg, .channel_access_window_n, .frame_phase_out);
  sts_line_model i_sts_line_model (.clk_sys, .rst_n, .window_n(channel_access_window_n),
    .good, .rx_pos, .rx_neg);

  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) pw <= channel_access_window_n;

  task automatic end_sim();
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic step(inout int n);
    @(posedge clk_sys);
    n++;
    if (n > 40000)
    begin
      failures++;
      end_sim();
    end
  endtask

  // Host traffic only while the access window is open.
  task automatic win_low();
    int n = 0;
    do step(n); while (channel_access_window_n !== 1'b0);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    win_low();
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do step(n); while (s_axi_awready !== 1'b1);
    {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    do step(n); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n = 0;
    win_low();
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do step(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do step(n); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    `CHK(s_axi_rresp, er)
  endtask

  task automatic frames(input int k);
    int n;
    repeat (k)
    begin
      n = 0;
      do step(n); while (!(pw === 1'b1 && channel_access_window_n === 1'b0));
    end
  endtask

  // Samples one whole transmitted frame in the middle of each bit.
  task automatic cap();
    frames(1);
    repeat (324) @(posedge clk_sys);
    for (int i = 0; i < 48; i++)
    begin
      mk[i] = tx_pos_q | tx_neg_q;
      pl[i] = tx_pos_q;
      repeat (651) @(posedge clk_sys);
    end
  endtask

  task automatic chk_line(input logic [7:0] b1, input logic fa, m, s, a, ca);
    logic [7:0] v;
    int vc = 0, vp = 0;
    logic lp;
    lp = pl[0];
    for (int i = 0; i < 8; i++) v[7 - i] = !mk[2 + i];
    `CHK(mk[0], 1'b1)
    `CHK(v, b1)
    `CHK(!mk[13], fa)
    `CHK(mk[14], fa)
    `CHK(!mk[25], m)
    `CHK(!mk[36], s)
    `CHK(^mk, 1'b0)
    if (ca)
    begin
      `CHK(!mk[12], a)
      `CHK(!mk[10], 1'b1)
    end
    for (int i = 1; i < 48; i++)
      if (mk[i])
      begin
        if (pl[i] == lp && vp == 0)
          vp = i;
        vc += (pl[i] == lp);
        lp = pl[i];
      end
    `CHK(vc, 1)
    `CHK(vp <= 14, 1'b1)
  endtask

  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    axi_rd(8'h00, 2'h0, rd);
    `CHK(rd, 32'h0)
    axi_rd(8'h04, 2'h0, rd);
    `CHK(rd, 32'h000FFFFF)
    axi_rd(8'h08, 2'h0, rd);
    `CHK(rd[0], 1'b0)
    axi_rd(8'h10, 2'h2, rd);
    axi_wr(8'h10, 32'h1, 2'h2);
    good <= 1'b1;
    axi_wr(8'h04, 32'h000FFFA5, 2'h0);
    axi_wr(8'h00, 32'h45, 2'h0);
    axi_wr(8'h00, 32'h51, 2'h0);
    cap();
    chk_line(8'hA5, 0, 1, 0, 0, 0);
    axi_wr(8'h00, 32'h43, 2'h0);
    cap();
    chk_line(8'hA5, 1, 0, 0, 0, 0);
    axi_wr(8'h00, 32'h51, 2'h0);
    frames(1);
    axi_rd(8'h08, 2'h0, rd);
    `CHK(rd[0], 1'b1)
    `CHK(frame_phase_out, 1'b1)
    `CHK(rd[4], 1'b1)
    cap();
    chk_line(8'hA5, 0, 0, 0, 1, 1);
    axi_wr(8'h00, 32'h71, 2'h0);
    good <= 1'b0;
    frames(4);
    axi_rd(8'h08, 2'h0, rd);
    `CHK(rd[0], 1'b1)
    axi_wr(8'h00, 32'h51, 2'h0);
    frames(4);
    axi_rd(8'h08, 2'h0, rd);
    `CHK(rd[0], 1'b0)
    end_sim();
  end
endmodule // tb_top

bind sts_frame_logic sts_frame_asserts i_sts_frame_asserts (.clk_sys, .rst_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .tx_pos_q, .tx_neg_q, .channel_access_window_n);
